// [src/vmf_top.v]
// Supply monitor filter and level control with AXI4-Lite register slave
// How it works
// [R01] Monitor 1 filter, switchable by bypass bit
// [R02] Monitor 2 filter, independently switchable
// [R03] Monitor 0 unfiltered, no event
// [R04] Sample slow clock divided 2/4/8/16
// [R05] Monitors 1,2 pulse event on crossing
// [R06] Monitor 1 code bits 3:0, five codes
// [R07] Monitor 2 code bits 7:4, same codes
// [R08] Software writes only valid codes
// [R09] Bypass 0 filters, 1 bypasses
// [R10] Software waits 2n+3 before output enable
// [R11] Output enable lets result reach detection
// [R12] Output changes after two agreeing samples
//
// Register map, one aligned word each
// Word 0x0 holds both threshold codes, monitor 1 low nibble, monitor 2 high
// Word 0x4 is monitor 1 control zero, word 0x8 monitor 2 control zero
// Word 0xC holds sticky status in byte 0 and the interrupt mask in byte 1
// Any other word answers with an error and reads as zero
//
// Control zero layout
// Bits 1:0 pick the sampling divider, 0..3 meaning 2, 4, 8 or 16
// Bit 2 bypasses the filter; reads of bit 2 show the filter result instead
// Bit 7 lets the result reach the detection output and the event logic
// After reset the filter is bypassed and the output is held off
//
// Monitor path
// Comparator pin, two synchroniser flops, filter, gating, output flop
// In bypass the filter adds one flop, so a pin change shows four cycles later
// With the filter on, the pin must be seen equal on two sampling instants
// Sampling instants come every n rising edges of the slow oscillator
// A glitch shorter than one sampling period can never move the output
//
// Events
// Any change of the gated level while enabled raises a one cycle event
// Event and detect outputs leave the same edge, so the link unit sees both
// Clearing the enable drops detect without an event, by design
//
// Status and interrupt
// Bit 0 and bit 1 record events of monitor 1 and 2, bit 2 a refused code
// Writing a one clears a bit; a new event in the same cycle still sets it
// The interrupt is the OR of status bits that the mask lets through
//
// Hazards and limits
// Software must wait for the filter to settle before raising the enable
// The wait is not enforced here; an early enable may give one stray event
// A level write with any bad code is refused whole, keeping both old codes
// Only one write and one read may be outstanding on the register bus
// The slow oscillator is sampled on the bus clock, so it must run slower
// than half the bus clock for every rising edge to be seen
//
`include "vmf_defines.vh"
module vmf_top (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_OSC_SLOW,
  input wire I_CMP0,
  input wire I_CMP1,
  input wire I_CMP2,
  input wire [3:0] I_AWADDR,
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output reg O_WREADY,
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  input wire [3:0] I_ARADDR,
  input wire I_ARVALID,
  output reg O_ARREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY,
  output reg O_MON0_DETECT,
  output reg O_MON1_DETECT,
  output reg O_MON2_DETECT,
  output reg O_EVENT1,
  output reg O_EVENT2,
  output reg [3:0] O_THRESH1_CODE,
  output reg [3:0] O_THRESH2_CODE,
  output reg O_IRQ
);
  // Software registers
  reg [7:0] level_q;
  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [2:0] status_q;
  reg [2:0] mask_q;
  // Write channel capture
  reg aw_got_q;
  reg [3:0] aw_addr_q;
  reg w_got_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  // Synchronised pins
  wire osc_s;
  wire cmp0_s;
  wire cmp1_s;
  wire cmp2_s;
  reg osc_prev_q;
  // Filter results
  wire res1;
  wire res2;
  // Previous gated results for crossing detection
  reg gated1_prev_q;
  reg gated2_prev_q;

  // All asynchronous pins pass two flops
  vmf_sync u_sync_osc (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_async(I_OSC_SLOW),
    .o_sync(osc_s));
  vmf_sync u_sync_c0 (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_async(I_CMP0),
    .o_sync(cmp0_s));
  vmf_sync u_sync_c1 (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_async(I_CMP1),
    .o_sync(cmp1_s));
  vmf_sync u_sync_c2 (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_async(I_CMP2),
    .o_sync(cmp2_s));

  // Rising edge of the slow oscillator, one cycle tick
  wire osc_tick = osc_s && !osc_prev_q;

  // [R01] monitor 1 filter
  vmf_filter u_filt1 (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_osc_tick(osc_tick),
    .i_divider(ctrl1_q[`VMF_CTL_DIV_LSB+1:`VMF_CTL_DIV_LSB]),
    .i_bypass(ctrl1_q[`VMF_CTL_BYPASS_BIT]),
    .i_cmp(cmp1_s),
    .o_result(res1)
  );
  // [R02] monitor 2 filter
  vmf_filter u_filt2 (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_osc_tick(osc_tick),
    .i_divider(ctrl2_q[`VMF_CTL_DIV_LSB+1:`VMF_CTL_DIV_LSB]),
    .i_bypass(ctrl2_q[`VMF_CTL_BYPASS_BIT]),
    .i_cmp(cmp2_s),
    .o_result(res2)
  );

  // [R11] output enable gating
  wire gated1 = ctrl1_q[`VMF_CTL_OUTEN_BIT] & res1;
  wire gated2 = ctrl2_q[`VMF_CTL_OUTEN_BIT] & res2;
  wire en1 = ctrl1_q[`VMF_CTL_OUTEN_BIT];
  wire en2 = ctrl2_q[`VMF_CTL_OUTEN_BIT];
  // [R05] crossing in either direction while enabled
  wire cross1 = en1 && (gated1 != gated1_prev_q);
  wire cross2 = en2 && (gated2 != gated2_prev_q);

  // Valid threshold code check
  // Only five codes select a threshold; every other code would leave the
  // analog side without a defined level, so it is refused outright
  function code_ok;
    input [3:0] c;
    begin
      code_ok = (c == `VMF_CODE_A) || (c == `VMF_CODE_B) || (c == `VMF_CODE_C) ||
                (c == `VMF_CODE_D) || (c == `VMF_CODE_E);
    end
  endfunction

  // Write takes place once both address and data are held
  // Either half may come first; a half that arrives alone is parked
  // until the other turns up, then both are used in one cycle
  wire wr_aw = aw_got_q || I_AWVALID;
  wire wr_w = w_got_q || I_WVALID;
  wire [3:0] wr_addr = aw_got_q ? aw_addr_q : I_AWADDR;
  wire [31:0] wr_data = w_got_q ? w_data_q : I_WDATA;
  wire [3:0] wr_strb = w_got_q ? w_strb_q : I_WSTRB;
  wire wr_fire = wr_aw && wr_w && !O_BVALID;
  wire wr_low = wr_strb[0];
  wire wr_mapped = (wr_addr == `VMF_ADDR_LEVEL) || (wr_addr == `VMF_ADDR_CTRL1) ||
                   (wr_addr == `VMF_ADDR_CTRL2) || (wr_addr == `VMF_ADDR_STATUS);
  // Mask has no word of its own: it sits in byte lane 1 of the status word, bits 10:8
  wire [3:0] lvl1_new = wr_data[`VMF_LVL1_LSB+3:`VMF_LVL1_LSB];
  wire [3:0] lvl2_new = wr_data[`VMF_LVL2_LSB+3:`VMF_LVL2_LSB];
  // [R08] rejected codes flagged, register keeps old field
  wire lvl_write = wr_fire && wr_low && (wr_addr == `VMF_ADDR_LEVEL);
  wire lvl_bad = lvl_write && !(code_ok(lvl1_new) && code_ok(lvl2_new));

  // Slow oscillator edge history
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
    end
  end

  // AXI write channel handling
  // Both ready lines stay low while a response waits, which keeps at most
  // one write in flight and spares a response queue
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      aw_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_got_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `VMF_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        // Both halves present: answer and close the channels until B is taken
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        O_AWREADY <= 1'b0;
        O_WREADY <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= (wr_mapped && !lvl_bad) ? `VMF_RESP_OKAY : `VMF_RESP_SLVERR;
      end else begin
        // Hold a half that arrived alone
        if (I_AWVALID && O_AWREADY) begin
          aw_got_q <= 1'b1;
          aw_addr_q <= I_AWADDR;
          O_AWREADY <= 1'b0;
        end
        if (I_WVALID && O_WREADY) begin
          w_got_q <= 1'b1;
          w_data_q <= I_WDATA;
          w_strb_q <= I_WSTRB;
          O_WREADY <= 1'b0;
        end
        if (O_BVALID && I_BREADY) begin
          O_BVALID <= 1'b0;
          O_AWREADY <= 1'b1;
          O_WREADY <= 1'b1;
        end
      end
    end
  end

  // Register writes, status sticky bits; set wins over write-one-to-clear
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      level_q <= `VMF_LEVEL_RESET;
      ctrl1_q <= `VMF_CTRL_RESET;
      ctrl2_q <= `VMF_CTRL_RESET;
      status_q <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      // [R06] [R07] only legal codes stored
      if (lvl_write && code_ok(lvl1_new) && code_ok(lvl2_new)) begin
        level_q <= wr_data[7:0];
      end
      // [R09] bypass bit written by software
      if (wr_fire && wr_low && (wr_addr == `VMF_ADDR_CTRL1)) begin
        ctrl1_q <= wr_data[7:0];
      end
      if (wr_fire && wr_low && (wr_addr == `VMF_ADDR_CTRL2)) begin
        ctrl2_q <= wr_data[7:0];
      end
      // Status byte lane 0 clears, lane 1 writes the mask
      if (wr_fire && (wr_addr == `VMF_ADDR_STATUS) && wr_strb[1]) begin
        mask_q <= wr_data[10:8];
      end
      status_q <= (status_q & ~((wr_fire && wr_low && (wr_addr == `VMF_ADDR_STATUS)) ?
                  wr_data[2:0] : 3'h0)) | {lvl_bad, cross2, cross1};
    end
  end

  // AXI read channel; one cycle answer
  // Read data is registered, so the answer stands one cycle after the
  // address is taken and holds until the master takes it
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= `VMF_RESP_OKAY;
    end else begin
      if (I_ARVALID && O_ARREADY) begin
        O_ARREADY <= 1'b0;
        O_RVALID <= 1'b1;
        O_RRESP <= `VMF_RESP_OKAY;
        case (I_ARADDR)
          `VMF_ADDR_LEVEL: O_RDATA <= {24'h000000, level_q};
          `VMF_ADDR_CTRL1: O_RDATA <= {24'h000000, ctrl1_q[7:3], res1, ctrl1_q[1:0]};
          `VMF_ADDR_CTRL2: O_RDATA <= {24'h000000, ctrl2_q[7:3], res2, ctrl2_q[1:0]};
          `VMF_ADDR_STATUS: O_RDATA <= {21'h000000, mask_q, 5'h00, status_q};
          default: begin
            // Unmapped word
            O_RDATA <= 32'h00000000;
            O_RRESP <= `VMF_RESP_SLVERR;
          end
        endcase
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

  // Monitor outputs, events and interrupt, all registered
  // Every output leaves a flop so the analog side and the event link
  // never see combinational glitches from the register decode
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      gated1_prev_q <= 1'b0;
      gated2_prev_q <= 1'b0;
      O_MON0_DETECT <= 1'b0;
      O_MON1_DETECT <= 1'b0;
      O_MON2_DETECT <= 1'b0;
      O_EVENT1 <= 1'b0;
      O_EVENT2 <= 1'b0;
      O_THRESH1_CODE <= `VMF_CODE_A;
      O_THRESH2_CODE <= `VMF_CODE_A;
      O_IRQ <= 1'b0;
    end else begin
      gated1_prev_q <= gated1;
      gated2_prev_q <= gated2;
      // [R03] monitor 0 straight through
      O_MON0_DETECT <= cmp0_s;
      // [R11] gated result to detection
      O_MON1_DETECT <= gated1;
      O_MON2_DETECT <= gated2;
      // [R05] one-cycle event pulses
      O_EVENT1 <= cross1;
      O_EVENT2 <= cross2;
      O_THRESH1_CODE <= level_q[`VMF_LVL1_LSB+3:`VMF_LVL1_LSB];
      O_THRESH2_CODE <= level_q[`VMF_LVL2_LSB+3:`VMF_LVL2_LSB];
      O_IRQ <= |(status_q & mask_q);
    end
  end
endmodule // vmf_top

// [src/vmf_defines.vh]
// Register map, field positions, reset values and codes of the supply monitor filter block
`ifndef VMF_DEFINES_VH
`define VMF_DEFINES_VH
// Byte addresses of the registers
`define VMF_ADDR_LEVEL 4'h0
`define VMF_ADDR_CTRL1 4'h4
`define VMF_ADDR_CTRL2 4'h8
`define VMF_ADDR_STATUS 4'hC
`define VMF_ADDR_MASK 4'h0
`define VMF_ADDR_MASK_HI 1'b1
// Level select register fields
`define VMF_LVL1_LSB 0
`define VMF_LVL2_LSB 4
`define VMF_LEVEL_RESET 8'h44
// Control register zero fields
`define VMF_CTL_DIV_LSB 0
`define VMF_CTL_BYPASS_BIT 2
`define VMF_CTL_OUTEN_BIT 7
`define VMF_CTRL_RESET 8'h04
// Status and mask fields
`define VMF_EVT1_BIT 0
`define VMF_EVT2_BIT 1
`define VMF_LVLERR_BIT 2
// Valid threshold codes
`define VMF_CODE_A 4'h4
`define VMF_CODE_B 4'h5
`define VMF_CODE_C 4'h6
`define VMF_CODE_D 4'hA
`define VMF_CODE_E 4'hB
// AXI responses
`define VMF_RESP_OKAY 2'h0
`define VMF_RESP_SLVERR 2'h2
`endif

// [src/vmf_sync.v]
// Two-flop synchroniser for one asynchronous level
module vmf_sync (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_async,
  output reg o_sync
);
  // First stage, read only by the second
  reg meta_q;

  // Plain double register; reset values are constants
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // vmf_sync

// [src/vmf_filter.v]
// Digital filter for one monitor, sampling on divided slow oscillator ticks
module vmf_filter (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_osc_tick,
  input wire [1:0] i_divider,
  input wire i_bypass,
  input wire i_cmp,
  output reg o_result
);
  // Divider counter of slow oscillator ticks
  reg [3:0] div_cnt_q;
  // Last sample taken
  reg sample_q;
  // Terminal count: n-1 where n = 2,4,8,16
  wire [3:0] div_top = (4'h2 << i_divider) - 4'h1;
  // One sampling instant
  wire samp_now = i_osc_tick && (div_cnt_q >= div_top);

  // Sampling clock divider and two-sample agreement
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_cnt_q <= 4'h0;
      sample_q <= 1'b0;
      o_result <= 1'b0;
    end else begin
      if (i_osc_tick) begin
        // [R04] divide by n
        div_cnt_q <= samp_now ? 4'h0 : div_cnt_q + 4'h1;
      end
      if (i_bypass) begin
        // Bypass passes comparator through and keeps history aligned
        sample_q <= i_cmp;
        o_result <= i_cmp;
      end else if (samp_now) begin
        sample_q <= i_cmp;
        // [R12] two samples agree
        if (sample_q == i_cmp) begin
          o_result <= i_cmp;
        end
      end
    end
  end
endmodule // vmf_filter

// [verification/vmf_partner.sv]
// Model of the analog comparators and the free-running slow oscillator
module vmf_partner #(
  parameter int OSC_HALF = 125
) (
  input wire logic [2:0] i_above,
  output logic o_osc,
  output logic [2:0] o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow oscillator never stops, so it toggles outside any transfer too
  initial o_osc = 1'b0;
  always #(OSC_HALF) o_osc = ~o_osc;
  // Comparators answer after a short analog delay, never in step with the bus clock
  assign #3 o_cmp = i_above;
endmodule // vmf_partner

// [verification/vmf_assertions.sv]
// Port-level assertions for the supply monitor filter block
module vmf_assertions (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_CMP0,
  input wire I_CMP1,
  input wire I_CMP2,
  input wire O_AWREADY,
  input wire O_BVALID,
  input wire O_ARREADY,
  input wire O_RVALID,
  input wire O_MON0_DETECT,
  input wire O_MON1_DETECT,
  input wire O_MON2_DETECT,
  input wire O_EVENT1,
  input wire O_EVENT2,
  input wire [3:0] O_THRESH1_CODE,
  input wire [3:0] O_THRESH2_CODE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Long enough for the two synchroniser flops and the output register
  sequence s_cmp0_calm;
    $stable(I_CMP0) [*5];
  endsequence
  sequence s_det1_rise;
    $rose(O_MON1_DETECT);
  endsequence
  a_mon0_follow: assert property (s_cmp0_calm |-> O_MON0_DETECT == I_CMP0)
    else $error("monitor 0 does not follow comparator");
  a_mon1_cause: assert property (s_det1_rise |-> $past(I_CMP1, 2))
    else $error("monitor 1 rose without comparator");
  a_mon2_cause: assert property ($rose(O_MON2_DETECT) |-> $past(I_CMP2, 2))
    else $error("monitor 2 rose without comparator");
  // Event and detect are registered from the same gated level, so they move together except when the enable is cleared
  a_ev1_rise: assert property (s_det1_rise |-> O_EVENT1)
    else $error("no event 1 with detect rise");
  a_ev2_rise: assert property ($rose(O_MON2_DETECT) |-> O_EVENT2)
    else $error("no event 2 with detect rise");
  a_ev1_cause: assert property (O_EVENT1 |-> $changed(O_MON1_DETECT))
    else $error("event 1 without detect change");
  a_ev2_single: assert property (O_EVENT2 |=> !O_EVENT2)
    else $error("event 2 longer than one cycle");
  a_code1_valid: assert property (O_THRESH1_CODE inside {4'h4, 4'h5, 4'h6, 4'hA, 4'hB})
    else $error("threshold code 1 invalid");
  a_code2_valid: assert property (O_THRESH2_CODE inside {4'h4, 4'h5, 4'h6, 4'hA, 4'hB})
    else $error("threshold code 2 invalid");
  a_bus_busy: assert property ((O_BVALID |-> !O_AWREADY) and (O_RVALID |-> !O_ARREADY))
    else $error("ready high while answer pending");
endmodule // vmf_assertions
bind vmf_top vmf_assertions vmf_assertions_inst (.*);

// [verification/tb.sv]
// Self-checking bench for the supply monitor filter block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLK = 1'b0, I_RESET_N = 1'b0, I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0;
  logic I_ARVALID = 1'b0, I_RREADY = 1'b0;
  logic [3:0] I_AWADDR = 4'h0, I_ARADDR = 4'h0, I_WSTRB = 4'h0;
  logic [31:0] I_WDATA = 32'h0;
  logic [2:0] above = 3'h0;
  wire I_OSC_SLOW, I_CMP0, I_CMP1, I_CMP2, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  wire O_MON0_DETECT, O_MON1_DETECT, O_MON2_DETECT, O_EVENT1, O_EVENT2, O_IRQ;
  wire [1:0] O_BRESP, O_RRESP;
  wire [31:0] O_RDATA;
  wire [3:0] O_THRESH1_CODE, O_THRESH2_CODE;
  int n_fail = 0, comparisons = 0;
  int ev1_cnt = 0, ev2_cnt = 0;
  vmf_top vmf_top_inst (.*);
  vmf_partner vmf_partner_inst (.i_above(above), .o_osc(I_OSC_SLOW),
    .o_cmp({I_CMP2, I_CMP1, I_CMP0}));
  always #12.5 I_CLK = ~I_CLK;
  // Count event pulses as the event link unit would see them
  always @(posedge I_CLK) begin
    if (O_EVENT1 === 1'b1) ev1_cnt <= ev1_cnt + 1;
    if (O_EVENT2 === 1'b1) ev2_cnt <= ev2_cnt + 1;
  end
  // Case equality so an unknown never counts as a match
  task chk(input [31:0] got, input [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task wr(input [3:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    @(posedge I_CLK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_WSTRB <= s;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    fork
      begin do @(posedge I_CLK); while (!O_AWREADY); I_AWVALID <= 1'b0; end
      begin do @(posedge I_CLK); while (!O_WREADY); I_WVALID <= 1'b0; end
    join
    while (!O_BVALID) @(posedge I_CLK);
    r = O_BRESP;
    I_BREADY <= 1'b0;
  endtask
  task rd(input [3:0] a, output [31:0] d);
    @(posedge I_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do @(posedge I_CLK); while (!O_ARREADY);
    I_ARVALID <= 1'b0;
    do @(posedge I_CLK); while (!O_RVALID);
    d = O_RDATA;
    I_RREADY <= 1'b0;
  endtask
  // Every valid code in both fields, then a refused code pair
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] c [5] = '{4'h4, 4'h5, 4'h6, 4'hA, 4'hB};
    rd(4'h0, d);
    chk(d, 32'h44);
    foreach (c[i]) begin
      wr(4'h0, {24'h0, c[i], c[(i + 1) % 5]}, 4'h1, r);
      rd(4'h0, d);
      chk(d, {24'h0, c[i], c[(i + 1) % 5]});
      chk({O_THRESH2_CODE, O_THRESH1_CODE}, {c[i], c[(i + 1) % 5]});
    end
    wr(4'h0, 32'h37, 4'h1, r);
    chk(r, 2'h2);
    rd(4'h0, d);
    chk(d, 32'hB4);
    rd(4'hC, d);
    chk(d[2], 1'b1);
    $display("done regs");
  endtask
  // Bypassed filter with output enable on, then output enable off
  task t_mon;
    logic [1:0] r;
    int e0;
    for (int m = 1; m < 3; m++) begin
      wr(4'(4 * m), 32'h84, 4'h1, r);
      e0 = (m == 1) ? ev1_cnt : ev2_cnt;
      above <= 3'h7;
      repeat (8) @(posedge I_CLK);
      chk(m == 1 ? O_MON1_DETECT : O_MON2_DETECT, 1'b1);
      chk(((m == 1) ? ev1_cnt : ev2_cnt) - e0, 1);
      chk(O_MON0_DETECT, 1'b1);
      wr(4'(4 * m), 32'h04, 4'h1, r);
      repeat (4) @(posedge I_CLK);
      chk(m == 1 ? O_MON1_DETECT : O_MON2_DETECT, 1'b0);
      above <= 3'h0;
      repeat (8) @(posedge I_CLK);
    end
    $display("done monitors");
  endtask
  // Filter on at each divider: glitch rejected, response near two sample periods
  task t_filt;
    logic [1:0] r;
    int n, k;
    for (int dv = 0; dv < 4; dv++) begin
      n = 2 << dv;
      wr(4'h4, dv, 4'h1, r);
      repeat (2 * n + 3) @(posedge I_OSC_SLOW);
      wr(4'h4, 32'h80 | dv, 4'h1, r);
      @(posedge I_CLK) above <= 3'h2;
      @(posedge I_CLK) above <= 3'h0;
      repeat (30 * n) @(posedge I_CLK);
      chk(O_MON1_DETECT, 1'b0);
      above <= 3'h2;
      k = 0;
      while (!O_MON1_DETECT && k < 40 * n + 20) begin
        @(posedge I_CLK);
        k++;
      end
      chk(k >= 10 * n && k <= 30 * n + 10, 1'b1);
      above <= 3'h0;
      repeat (40 * n) @(posedge I_CLK);
    end
    $display("done filter");
  endtask
  // Unmask, mask and clear the monitor 1 event status
  task t_irq;
    logic [31:0] d;
    logic [1:0] r;
    wr(4'hC, 32'h100, 4'h2, r);
    repeat (2) @(posedge I_CLK);
    chk(O_IRQ, 1'b1);
    wr(4'hC, 32'h0, 4'h2, r);
    repeat (2) @(posedge I_CLK);
    chk(O_IRQ, 1'b0);
    wr(4'hC, 32'h7, 4'h1, r);
    rd(4'hC, d);
    chk(d[2:0], 3'h0);
    $display("done interrupt");
  endtask
  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog well beyond the few thousand cycles the tests take
  initial begin
    #1500000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    t_regs;
    t_mon;
    t_filt;
    t_irq;
    test_done;
  end
endmodule // tb
